// File: design/tdr_fmt.sv
/*
 * Combinational formatter: builds one debug data word from a TLB entry.
 * Assumes the caller has checked the pointer and entry validity.
 */
`timescale 1ns/1ps
`include "tdr_map.svh"

module tdr_fmt (
   // Selected entry
   input wire tdr_pkg::tdr_entry_t entry_i,
   input wire logic entry_ok_i,
   input wire logic first_entry_i,
   // Selected word
   input wire logic [3:0] word_i,
   input wire logic ptr_ok_i,
   // Answer
   output tdr_pkg::tdr_word_t word_o
);

   // Payload, flags and position code of the selected word
   always_comb begin
      logic [31:0] d;
      logic [1:0] pos;
      logic info_bad;
      d = 32'h0000_0000; // Reserved bits read as zero
      pos = `TDR_POS_MID;
      info_bad = !ptr_ok_i || !entry_ok_i;
      unique case (word_i)
         `TDR_WORD_VA: begin
            d[31:4] = entry_i.lookup_va;
            pos = first_entry_i ? `TDR_POS_TLB0 : `TDR_POS_FIRST;
         end
         `TDR_WORD_ATTR: begin
            d = 32'h0000_0000; // Attribute word is not held here
         end
         `TDR_WORD_ID: begin
            d[31:17] = entry_i.stream_id;
            d[15:8] = entry_i.ctx_index;
            d[4] = entry_i.non_secure;
            d[`TDR_PVAL_BIT] = !ptr_ok_i; // Inverted sense
         end
         `TDR_WORD_PERM: begin
            d[31:17] = entry_i.stream_mask;
            d[12:11] = entry_i.entry_type;
            d[10] = entry_i.contig_hint;
            d[9] = entry_i.priv_exec_never;
            d[8] = entry_i.exec_never_flag;
            d[7:5] = entry_i.hyp_access_perm;
            d[4] = entry_i.access_flag_enable;
            d[`TDR_PVAL_BIT] = !ptr_ok_i;
         end
         `TDR_WORD_PHYS: begin
            d[31:4] = entry_i.phys_addr_field; // Bit 1 stays reserved
            pos = `TDR_POS_LAST;
         end
         default: begin
            info_bad = 1'b1; // No such word in an entry
         end
      endcase
      if (info_bad) begin
         d = 32'h0000_0000; // Hide stale contents of a bad selection
         if (word_i == `TDR_WORD_ID || word_i == `TDR_WORD_PERM) begin
            d[`TDR_PVAL_BIT] = !ptr_ok_i;
         end
      end
      d[`TDR_INFO_HI:`TDR_INFO_LO] = info_bad ? `TDR_INFO_BAD : `TDR_INFO_OK;
      d[`TDR_POS_BIT] = pos[0]; // Only one bit fits here
      word_o.data = d;
      word_o.entry_position_code = pos;
   end

endmodule : tdr_fmt

// File: design/tdr_map.svh
/*
 * Register offsets, field positions, reset values and sizes of the TLB
 * debug readout block. Assumes byte addressing on a 32-bit register bus.
 */
`ifndef TDR_MAP_SVH
`define TDR_MAP_SVH

// Register byte offsets
`define TDR_OFS_PTR 4'h0
`define TDR_OFS_DATA 4'h4
`define TDR_OFS_POS 4'h8
`define TDR_OFS_STAT 4'hC

// Pointer register fields
`define TDR_PTR_ENT_HI 15
`define TDR_PTR_ENT_LO 4
`define TDR_PTR_WRD_HI 3
`define TDR_PTR_WRD_LO 0
`define TDR_PTR_RESET 16'h0000

// Entry storage
`define TDR_ENTRIES 16
`define TDR_IDX_W 4

// Word numbers
`define TDR_WORD_VA 4'h1
`define TDR_WORD_ATTR 4'h2
`define TDR_WORD_ID 4'h3
`define TDR_WORD_PERM 4'h4
`define TDR_WORD_PHYS 4'h5

// Flag positions; info and position bits in every word, pointer flag in words 3 and 4 only
`define TDR_INFO_HI 3
`define TDR_INFO_LO 2
`define TDR_PVAL_BIT 1
`define TDR_POS_BIT 0
`define TDR_INFO_OK 2'h0
`define TDR_INFO_BAD 2'h1

// Entry-position codes
`define TDR_POS_MID 2'h0
`define TDR_POS_FIRST 2'h1
`define TDR_POS_LAST 2'h2
`define TDR_POS_TLB0 2'h3

`endif

// File: design/tdr_pkg.sv
/*
 * Types of the TLB debug readout block: the stored entry and the
 * formatted answer. Assumes nothing beyond a SystemVerilog compiler.
 */
package tdr_pkg;

   // Entry type codes
   typedef enum logic [1:0] {
      TDR_ET_XLATE = 2'h0,
      TDR_ET_NOXLATE = 2'h1,
      TDR_ET_S2BYPASS = 2'h2,
      TDR_ET_USFBYPASS = 2'h3
   } tdr_etype_t;

   // One TLB entry as the translation logic fills it
   typedef struct packed {
      logic [27:0] lookup_va;
      logic [14:0] stream_id;
      logic [7:0] ctx_index;
      logic non_secure;
      logic [14:0] stream_mask;
      tdr_etype_t entry_type;
      logic contig_hint;
      logic priv_exec_never;
      logic exec_never_flag;
      logic [2:0] hyp_access_perm;
      logic access_flag_enable;
      logic [27:0] phys_addr_field;
   } tdr_entry_t;

   // Formatted debug word with its full position code
   typedef struct packed {
      logic [31:0] data;
      logic [1:0] entry_position_code;
   } tdr_word_t;

endpackage : tdr_pkg

// File: design/tdr_top.sv
/*
 * TLB debug readout: holds TLB entries filled by the translation logic
 * and returns one 32-bit word of a chosen entry per debug read.
 * Assumes an Avalon-MM master on the same clock and a fill port driven
 * by same-clock logic, so neither path is synchronised.
 */
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "tdr_map.svh"

module tdr_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Entry fill from the translation logic
   input wire logic fill_valid_i,
   input wire logic [`TDR_IDX_W-1:0] fill_index_i,
   input wire tdr_pkg::tdr_entry_t fill_entry_i,
   input wire logic flush_all_i,
   // Debug view
   output logic [1:0] entry_position_code_o,
   output logic read_done_o
);

   // Bus handshake states
   typedef enum logic {
      TDR_S_IDLE,
      TDR_S_ACK
   } tdr_bus_state_t;

   // Address decode, shared by read and write paths
   function automatic logic tdr_is_reg(input logic [3:0] addr, input logic [3:0] ofs);
      tdr_is_reg = (addr == ofs);
   endfunction : tdr_is_reg

   tdr_bus_state_t state_q;
   tdr_bus_state_t state_d;
   logic wait_q;
   logic wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [15:0] ptr_q;
   logic [15:0] ptr_d;
   logic [1:0] pos_q;
   logic [1:0] pos_d;
   logic done_q;
   logic done_d;
   logic [`TDR_ENTRIES-1:0] valid_q;
   logic [`TDR_ENTRIES-1:0] valid_d;
   logic [15:0] reads_q;
   logic [15:0] reads_d;

   // Entry storage; contents need no reset, validity does
   tdr_pkg::tdr_entry_t mem_q [`TDR_ENTRIES];

   logic [11:0] sel_entry;
   logic [3:0] sel_word;
   logic ptr_ok;
   logic [`TDR_IDX_W-1:0] sel_idx;
   tdr_pkg::tdr_entry_t sel_ent;
   tdr_pkg::tdr_word_t fmt_word;
   logic req;

   // Pointer fields
   assign sel_entry = ptr_q[`TDR_PTR_ENT_HI:`TDR_PTR_ENT_LO];
   assign sel_word = ptr_q[`TDR_PTR_WRD_HI:`TDR_PTR_WRD_LO];
   // Pointers past the stored entries are reported invalid
   assign ptr_ok = (sel_entry < 12'(`TDR_ENTRIES));
   assign sel_idx = sel_entry[`TDR_IDX_W-1:0];
   assign sel_ent = mem_q[sel_idx];
   assign req = avs_read_i || avs_write_i;

   // Word formatter
   tdr_fmt u_fmt (
      .entry_i(sel_ent),
      .entry_ok_i(ptr_ok && valid_q[sel_idx]),
      .first_entry_i(sel_entry == 12'h000),
      .word_i(sel_word),
      .ptr_ok_i(ptr_ok),
      .word_o(fmt_word)
   );

   // Entry storage writes; same-clock source so no synchroniser
   always_ff @(posedge clk_i) begin
      if (fill_valid_i) begin
         mem_q[fill_index_i] <= fill_entry_i;
      end
   end

   // Validity: a fill in the flush cycle survives the flush
   always_comb begin
      valid_d = valid_q;
      if (flush_all_i) begin
         valid_d = '0;
      end
      if (fill_valid_i) begin
         valid_d[fill_index_i] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         valid_q <= '0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // Bus slave: one wait cycle, then waitrequest low for exactly one
   // cycle. Holding waitrequest high while idle keeps timing fixed.
   always_comb begin
      state_d = state_q;
      wait_d = 1'b1;
      rdata_d = rdata_q;
      ptr_d = ptr_q;
      pos_d = pos_q;
      done_d = 1'b0;
      reads_d = reads_q;
      unique case (state_q)
         TDR_S_IDLE: begin
            if (req) begin
               state_d = TDR_S_ACK;
               wait_d = 1'b0;
               rdata_d = 32'h0000_0000; // Unmapped reads return zero
               if (avs_read_i) begin
                  if (tdr_is_reg(avs_address_i, `TDR_OFS_PTR)) begin
                     rdata_d = {16'h0000, ptr_q}; // Upper half reserved
                  end else if (tdr_is_reg(avs_address_i, `TDR_OFS_DATA)) begin
                     rdata_d = fmt_word.data;
                     pos_d = fmt_word.entry_position_code;
                     done_d = 1'b1;
                     reads_d = reads_q + 16'h0001;
                  end else if (tdr_is_reg(avs_address_i, `TDR_OFS_POS)) begin
                     rdata_d = {30'h0000_0000, pos_q};
                  end else if (tdr_is_reg(avs_address_i, `TDR_OFS_STAT)) begin
                     rdata_d = {reads_q, valid_q};
                  end
               end else if (tdr_is_reg(avs_address_i, `TDR_OFS_PTR)) begin
                  // Writes honour byte lanes; upper lanes are reserved
                  if (avs_byteenable_i[0]) begin
                     ptr_d[7:0] = avs_writedata_i[7:0];
                  end
                  if (avs_byteenable_i[1]) begin
                     ptr_d[15:8] = avs_writedata_i[15:8];
                  end
               end
            end
         end
         TDR_S_ACK: begin
            state_d = TDR_S_IDLE; // Master releases at this edge
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= TDR_S_IDLE;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         ptr_q <= `TDR_PTR_RESET;
         pos_q <= `TDR_POS_MID;
         done_q <= 1'b0;
         reads_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         ptr_q <= ptr_d;
         pos_q <= pos_d;
         done_q <= done_d;
         reads_q <= reads_d;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign entry_position_code_o = pos_q;
   assign read_done_o = done_q;

endmodule : tdr_top

// File: verification/tdr_properties.sv
/* Checker for tdr_top: bus answer timing and debug word format.
   Assumes a bind to tdr_top; the pointer shadow follows the byte enables. */
`timescale 1ns/1ps
module tdr_check (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register bus
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Debug view
   input wire logic [1:0] entry_position_code_o,
   input wire logic read_done_o
);
   logic [15:0] ptr_q;
   logic [15:0] ptr_d;
   logic [3:0] w;
   logic bad;
   logic rd;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // Pointer shadow, taken at the answer edge; still ahead of any later read
   always_comb begin
      ptr_d = ptr_q;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) begin
         // Only lanes 0 and 1 hold pointer bits
         if (avs_byteenable_i[0]) begin
            ptr_d[7:0] = avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            ptr_d[15:8] = avs_writedata_i[15:8];
         end
      end
   end
   always_ff @(posedge clk_i) begin
      ptr_q <= srst_i ? 16'h0000 : ptr_d;
   end
   // Decoded shadow
   assign w = ptr_q[3:0];
   assign bad = ptr_q[15:4] > 12'h00F;
   assign rd = read_done_o;
   answer_time_a: assert property (
      $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o) else $error("answer late");
   answer_pulse_a: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
   done_cause_a: assert property (
      rd |-> !avs_waitrequest_o && $past(avs_read_i) && $past(avs_address_i) == 4'h4)
      else $error("stray read done");
   pos_code_a: assert property (
      rd && w != 4'h1 |-> entry_position_code_o == {w == 4'h5, 1'h0}
         && avs_readdata_o[0] == 1'h0) else $error("position code wrong");
   first_word_a: assert property (
      rd && w == 4'h1 |-> entry_position_code_o == {ptr_q[15:4] == 12'h000, 1'h1})
      else $error("first word code wrong");
   info_range_a: assert property (
      rd && bad |-> avs_readdata_o[3:2] == 2'h1) else $error("info flag wrong");
   ptr_flag_a: assert property (
      rd && (w == 4'h3 || w == 4'h4) |-> avs_readdata_o[1] == bad) else $error("pointer flag");
   id_reserved_a: assert property (
      rd && w == 4'h3 |-> avs_readdata_o[16] == 1'h0 && avs_readdata_o[7:5] == 3'h0)
      else $error("word 3 reserved set");
   perm_reserved_a: assert property (
      rd && w == 4'h4 |-> avs_readdata_o[16:13] == 4'h0) else $error("word 4 reserved set");
   phys_bit1_a: assert property (
      rd && w == 4'h5 |-> avs_readdata_o[1] == 1'h0) else $error("word 5 bit 1 set");
endmodule : tdr_check
bind tdr_top tdr_check u_chk (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .entry_position_code_o(entry_position_code_o), .read_done_o(read_done_o));

// File: verification/tdr_top_test.sv
/* Self-checking bench for tdr_top: random fills, pointer sweeps, data reads.
   Assumes a single 20 MHz clock; the bench is the bus master and the fill source. */
`timescale 1ns/1ps
module tdr_top_test;
   logic clk_i, srst_i, avs_read_i, avs_write_i, fill_valid_i, flush_all_i;
   logic avs_waitrequest_o, read_done_o, done_s;
   logic [3:0] avs_address_i, fill_index_i, be;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic [1:0] entry_position_code_o, pos_s;
   logic [15:0] vld, last_p, nrd;
   logic [33:0] ex;
   tdr_pkg::tdr_entry_t fill_entry_i;
   tdr_pkg::tdr_entry_t mem [16];
   integer errors, checks, seed, i, j;
   localparam logic [11:0] CORN [5] = '{12'h000, 12'h007, 12'h00F, 12'h010, 12'hFFF};
   tdr_top DUT (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .fill_valid_i(fill_valid_i),
      .fill_index_i(fill_index_i), .fill_entry_i(fill_entry_i), .flush_all_i(flush_all_i),
      .entry_position_code_o(entry_position_code_o), .read_done_o(read_done_o));
   // 50 ns period
   always #25 clk_i = ~clk_i;
   task wrap_up;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : cmp32
   task cmp2(input string n, input logic [1:0] e, input logic [1:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : cmp2
   // One bus cycle; the idle edge first keeps releases and requests in separate steps
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      integer n;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'h0 && n < 20);
      if (avs_waitrequest_o !== 1'h0) begin
         errors++;
         wrap_up();
      end else begin
         q = avs_readdata_o;
         pos_s = entry_position_code_o;
         done_s = read_done_o;
         avs_read_i <= 1'h0;
         avs_write_i <= 1'h0;
      end
   endtask : bus
   // Random entry into slot k; type follows the slot so every code gets stored
   task fill(input logic [3:0] k, input logic fl);
      logic [127:0] r;
      @(posedge clk_i);
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      mem[k] = tdr_pkg::tdr_entry_t'(r[103:0]);
      mem[k].entry_type = tdr_pkg::tdr_etype_t'(k[1:0]);
      fill_entry_i <= mem[k];
      fill_index_i <= k;
      fill_valid_i <= 1'h1;
      flush_all_i <= fl;
      vld = fl ? 16'h0000 : vld;
      vld[k] = 1'h1;
      @(posedge clk_i);
      fill_valid_i <= 1'h0;
      flush_all_i <= 1'h0;
   endtask : fill
   function automatic logic [33:0] expect_word(input logic [15:0] pp);
      logic [11:0] e;
      logic [3:0] w;
      logic bad;
      logic [27:0] pl;
      logic [1:0] pos;
      tdr_pkg::tdr_entry_t m;
      e = pp[15:4];
      w = pp[3:0];
      m = mem[e[3:0]];
      bad = e > 12'h00F || !vld[e[3:0]] || w == 4'h0 || w > 4'h5;
      case (w)
         4'h1: pl = m.lookup_va;
         4'h3: pl = {m.stream_id, 1'h0, m.ctx_index, 3'h0, m.non_secure};
         4'h4: pl = {m.stream_mask, 4'h0, m.entry_type, m.contig_hint, m.priv_exec_never,
            m.exec_never_flag, m.hyp_access_perm, m.access_flag_enable};
         4'h5: pl = m.phys_addr_field;
         default: pl = 28'h0000000;
      endcase
      pl = bad ? 28'h0000000 : pl;
      pos = w == 4'h1 ? {e == 12'h000, 1'h1} : {w == 4'h5, 1'h0};
      return {pos, pl, 1'h0, bad, (w == 4'h3 || w == 4'h4) && e > 12'h00F, pos[0]};
   endfunction : expect_word
   // Pointer write with noise in the upper half, read back, then the data word
   task probe(input logic [15:0] pp);
      ex = expect_word(pp);
      last_p = pp;
      bus(1'h1, 4'h0, {16'($random(seed)), pp});
      bus(1'h0, 4'h0, 32'h00000000);
      cmp32("pointer", {16'h0000, pp}, q);
      bus(1'h0, 4'h4, 32'h00000000);
      nrd = nrd + 16'h0001;
      cmp32("data word", ex[31:0], q);
      cmp2("position pin", ex[33:32], pos_s);
      cmp2("read done", 2'h1, {1'h0, done_s});
      bus(1'h0, 4'h8, 32'h00000000);
      cmp2("position reg", ex[33:32], q[1:0]);
   endtask : probe
   initial begin
      clk_i = 1'h0;
      srst_i = 1'h1;
      {avs_read_i, avs_write_i, fill_valid_i, flush_all_i} = 4'h0;
      avs_address_i = 4'h0;
      fill_index_i = 4'h0;
      avs_writedata_i = 32'h00000000;
      fill_entry_i = '0;
      {errors, checks, vld, nrd} = 0;
      be = 4'hF;
      seed = 32'he8300de3;
      repeat (6) @(posedge clk_i);
      srst_i <= 1'h0;
      for (i = 0; i < 16; i++) fill(i[3:0], 1'h0);
      fill(4'h7, 1'h1);
      for (j = 1; j < 6; j++) probe({12'h000, j[3:0]});
      for (i = 1; i < 6; i++) fill(i[3:0], 1'h0);
      repeat (6) fill(4'($random(seed)), 1'h0);
      bus(1'h0, 4'hC, 32'h00000000);
      cmp32("valid map", {nrd, vld}, q);
      for (i = 0; i < 5; i++)
         for (j = 0; j < 7; j++) probe({CORN[i], j[3:0]});
      repeat (40) probe({7'h00, 5'($random(seed)), 1'h0, 3'($random(seed))});
      bus(1'h1, 4'h4, 32'hFFFFFFFF);
      bus(1'h0, 4'h0, 32'h00000000);
      cmp32("pointer kept", {16'h0000, last_p}, q);
      bus(1'h0, 4'h2, 32'h00000000);
      cmp32("unmapped", 32'h00000000, q);
      // Low lane only: the upper pointer byte must keep its value
      be <= 4'h1;
      bus(1'h1, 4'h0, 32'hFFFFA5C3);
      be <= 4'hF;
      bus(1'h0, 4'h0, 32'h00000000);
      cmp32("pointer low lane", {16'h0000, last_p[15:8], 8'hC3}, q);
      // Reset in mid-run clears pointer, read count and validity
      srst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'h0;
      bus(1'h0, 4'h0, 32'h00000000);
      cmp32("pointer after reset", 32'h00000000, q);
      bus(1'h0, 4'hC, 32'h00000000);
      cmp32("status after reset", 32'h00000000, q);
      wrap_up();
   end
endmodule : tdr_top_test
